// ---- rtl/ssrl_regs.svh ----
// Purpose: offsets, field positions and reset values of the serial loader
// Assumes: 32-bit words, control field in the four low bits
// Notes:   definitions only
`ifndef SSRL_REGS_SVH
`define SSRL_REGS_SVH

`define SSRL_WORD_W        32
`define SSRL_CTRL_W        4
`define SSRL_NUM_LATCH     13
`define SSRL_LAST_IDX      4'hC
`define SSRL_LATCH_RST     32'h0000_0000

`define SSRL_IDX_INT       4'h0
`define SSRL_IDX_PFRAC     4'h1
`define SSRL_IDX_AUX       4'h2
`define SSRL_IDX_PHASE     4'h3
`define SSRL_IDX_CFG       4'h4
`define SSRL_IDX_OUT       4'h6

// register 0
`define SSRL_INT_LSB       4
`define SSRL_AUTOCAL_BIT   21
// register 1
`define SSRL_PFRAC_LSB     4
// register 2
`define SSRL_AMOD_LSB      4
`define SSRL_AFRAC_LSB     18
// register 3
`define SSRL_PHASE_LSB     4
// register 4
`define SSRL_MONSEL_LSB    27
`define SSRL_DOUBLER_BIT   26
`define SSRL_HALVER_BIT    25
`define SSRL_RCOUNT_LSB    15
`define SSRL_DBUF_BIT      14
`define SSRL_CPCUR_LSB     10
`define SSRL_REFDIFF_BIT   9
`define SSRL_PDPOL_BIT     7
// register 6
`define SSRL_OUTDIV_LSB    21
`define SSRL_MUTE_BIT      11
`define SSRL_PWR_LSB       4

// monitor select codes
`define SSRL_MON_LOW       3'h0
`define SSRL_MON_HIGH      3'h1
`define SSRL_MON_GND       3'h2
`define SSRL_MON_REFDIV    3'h3
`define SSRL_MON_FBDIV     3'h4
`define SSRL_MON_ALOCK     3'h5
`define SSRL_MON_DLOCK     3'h6

// calibration search: 2 oscillator bits plus 8 band bits
`define SSRL_CAL_BITS      10
`define SSRL_CAL_LAST      4'h9

`endif

// ---- rtl/ssrl_pkg.sv ----
// Purpose: types shared by the serial loader files
// Assumes: field widths as held by the synthesizer counters
// Notes:   constants live in ssrl_regs.svh
package ssrl_pkg;

  typedef logic [31:0] ssrl_word_t;

  typedef struct packed {
    logic [15:0] int_value;
    logic [23:0] primary_fraction_numerator;
    logic [13:0] auxiliary_fraction_numerator;
    logic [13:0] auxiliary_modulus;
    logic [9:0]  ref_count;
    logic        ref_doubler;
    logic        reference_halver;
    logic [23:0] phase_value;
    logic [3:0]  cp_current;
    logic [2:0]  out_div;
    logic [1:0]  out_power;
    logic        ref_differential;
    logic        pd_positive;
    logic        mute_until_locked;
    logic [2:0]  monitor_select;
  } ssrl_active_s;

  typedef struct packed {
    logic       busy;
    logic [1:0] vco_select;
    logic [7:0] band_select;
  } ssrl_cal_s;

  typedef enum logic {
    SSRL_CAL_IDLE,
    SSRL_CAL_RUN
  } ssrl_cal_state_e;

endpackage

// ---- rtl/ssrl_sync.sv ----
// Purpose: two-flop synchroniser for a group of asynchronous levels
// Assumes: each bit is an independent level
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
module ssrl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stage_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r  <= '0;
      stage_r <= '0;
    end else begin
      meta_r  <= async_in;
      stage_r <= meta_r;
    end
  end

  assign sync_out = stage_r;

endmodule

// ---- rtl/ssrl_loader.sv ----
// Purpose: serial programming section of a frequency synthesizer
// Assumes: serial clock well below clk_in / 4
// Notes:   all link and analog-side inputs are sampled by two flip-flops
`timescale 1ns/1ps
`include "ssrl_regs.svh"
module ssrl_loader
  import ssrl_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  input  wire logic   serial_clk_in,
  input  wire logic   serial_data_in,
  input  wire logic   latch_load_strobe_in,
  input  wire logic   digital_lock_in,
  input  wire logic   analog_lock_in,
  input  wire logic   ref_div_clk_in,
  input  wire logic   feedback_div_clk_in,
  input  wire logic   tune_high_in,
  output ssrl_active_s active_out,
  output ssrl_cal_s    cal_out,
  output logic         integer_mode_out,
  output logic         vtune_internal_ref_out,
  output logic         output_stage_enable_out,
  output logic         monitor_output_pin_out,
  output logic         bad_index_out
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [2:0] link_s;
  logic [4:0] ana_s;
  logic       sclk_s;
  logic       sdata_s;
  logic       strobe_s;
  logic       dlock_s;
  logic       alock_s;
  logic       refclk_s;
  logic       fbclk_s;
  logic       tune_s;

  ssrl_sync #(.WIDTH(3)) u_link_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({serial_clk_in, serial_data_in, latch_load_strobe_in}),
    .sync_out (link_s)
  );

  ssrl_sync #(.WIDTH(5)) u_ana_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({digital_lock_in, analog_lock_in, ref_div_clk_in,
                feedback_div_clk_in, tune_high_in}),
    .sync_out (ana_s)
  );

  assign {sclk_s, sdata_s, strobe_s}                  = link_s;
  assign {dlock_s, alock_s, refclk_s, fbclk_s, tune_s} = ana_s;

  ////////////////////////////////////////////////////////////////////////
  // shift register and latches

  ssrl_word_t shift_r;
  ssrl_word_t shift_nxt;
  logic       sclk_prev_r;
  logic       strobe_prev_r;
  logic       refclk_prev_r;
  ssrl_word_t latch_r   [`SSRL_NUM_LATCH];
  ssrl_word_t latch_nxt [`SSRL_NUM_LATCH];
  logic       bad_index_r;
  logic       bad_index_nxt;
  logic       load_ev;
  logic       load_r0;
  logic [3:0] ctrl;

  assign ctrl    = shift_r[`SSRL_CTRL_W-1:0];
  assign load_ev = strobe_s & ~strobe_prev_r;
  assign load_r0 = load_ev && (ctrl == `SSRL_IDX_INT);

  always_comb begin
    shift_nxt     = shift_r;
    bad_index_nxt = bad_index_r;
    for (int i = 0; i < `SSRL_NUM_LATCH; i++) begin
      latch_nxt[i] = latch_r[i];
    end
    if (sclk_s && !sclk_prev_r) begin
      // msb first: older bits move up toward bit 31
      shift_nxt = {shift_r[`SSRL_WORD_W-2:0], sdata_s};
    end
    if (load_ev) begin
      // indices 13..15 name no latch and are dropped
      if (ctrl <= `SSRL_LAST_IDX) begin
        latch_nxt[ctrl] = shift_r;
        bad_index_nxt   = 1'b0;
      end else begin
        bad_index_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift_r       <= '0;
      sclk_prev_r   <= 1'b0;
      strobe_prev_r <= 1'b0;
      refclk_prev_r <= 1'b0;
      bad_index_r   <= 1'b0;
      for (int i = 0; i < `SSRL_NUM_LATCH; i++) begin
        latch_r[i] <= `SSRL_LATCH_RST;
      end
    end else begin
      shift_r       <= shift_nxt;
      sclk_prev_r   <= sclk_s;
      strobe_prev_r <= strobe_s;
      refclk_prev_r <= refclk_s;
      bad_index_r   <= bad_index_nxt;
      for (int i = 0; i < `SSRL_NUM_LATCH; i++) begin
        latch_r[i] <= latch_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // active settings

  ssrl_active_s active_r;
  ssrl_active_s active_nxt;
  ssrl_word_t   l4;
  ssrl_word_t   l6;

  assign l4 = latch_r[`SSRL_IDX_CFG];
  assign l6 = latch_r[`SSRL_IDX_OUT];

  always_comb begin
    active_nxt = active_r;
    // immediate fields follow their latch one cycle later
    active_nxt.ref_differential  = l4[`SSRL_REFDIFF_BIT];
    active_nxt.pd_positive       = l4[`SSRL_PDPOL_BIT];
    active_nxt.monitor_select    = l4[`SSRL_MONSEL_LSB +: 3];
    active_nxt.out_power         = l6[`SSRL_PWR_LSB +: 2];
    active_nxt.mute_until_locked = l6[`SSRL_MUTE_BIT];
    if (!l4[`SSRL_DBUF_BIT]) begin
      active_nxt.out_div = l6[`SSRL_OUTDIV_LSB +: 3];
    end
    if (load_r0) begin
      // register 0 itself is taken from the word being loaded
      active_nxt.int_value = shift_r[`SSRL_INT_LSB +: 16];
      active_nxt.primary_fraction_numerator =
        latch_r[`SSRL_IDX_PFRAC][`SSRL_PFRAC_LSB +: 24];
      active_nxt.auxiliary_fraction_numerator =
        latch_r[`SSRL_IDX_AUX][`SSRL_AFRAC_LSB +: 14];
      active_nxt.auxiliary_modulus =
        latch_r[`SSRL_IDX_AUX][`SSRL_AMOD_LSB +: 14];
      active_nxt.phase_value =
        latch_r[`SSRL_IDX_PHASE][`SSRL_PHASE_LSB +: 24];
      active_nxt.ref_count   = l4[`SSRL_RCOUNT_LSB +: 10];
      active_nxt.ref_doubler = l4[`SSRL_DOUBLER_BIT];
      active_nxt.reference_halver = l4[`SSRL_HALVER_BIT];
      active_nxt.cp_current  = l4[`SSRL_CPCUR_LSB +: 4];
      if (l4[`SSRL_DBUF_BIT]) begin
        active_nxt.out_div = l6[`SSRL_OUTDIV_LSB +: 3];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      active_r <= '0;
    end else begin
      active_r <= active_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator and band calibration

  ssrl_cal_state_e cal_state_r;
  ssrl_cal_state_e cal_state_nxt;
  logic [3:0]      cal_step_r;
  logic [3:0]      cal_step_nxt;
  logic [9:0]      cal_code_r;
  logic [9:0]      cal_code_nxt;
  logic [9:0]      cal_bit;
  logic            ref_edge;

  assign ref_edge = refclk_s & ~refclk_prev_r;
  assign cal_bit  = 10'h200 >> cal_step_r;

  always_comb begin
    cal_state_nxt = cal_state_r;
    cal_step_nxt  = cal_step_r;
    cal_code_nxt  = cal_code_r;
    unique case (cal_state_r)
      SSRL_CAL_IDLE: begin
        if (load_r0 && shift_r[`SSRL_AUTOCAL_BIT]) begin
          cal_state_nxt = SSRL_CAL_RUN;
          cal_step_nxt  = 4'h0;
          cal_code_nxt  = 10'h200;
        end
      end
      SSRL_CAL_RUN: begin
        // successive approximation, one decision per reference edge
        if (load_r0 && shift_r[`SSRL_AUTOCAL_BIT]) begin
          cal_step_nxt = 4'h0;
          cal_code_nxt = 10'h200;
        end else if (ref_edge) begin
          if (tune_s) begin
            cal_code_nxt = cal_code_r & ~cal_bit;
          end
          if (cal_step_r == `SSRL_CAL_LAST) begin
            cal_state_nxt = SSRL_CAL_IDLE;
          end else begin
            cal_step_nxt = cal_step_r + 4'h1;
            cal_code_nxt = (tune_s ? (cal_code_r & ~cal_bit) : cal_code_r)
                           | (cal_bit >> 1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cal_state_r <= SSRL_CAL_IDLE;
      cal_step_r  <= 4'h0;
      cal_code_r  <= 10'h000;
    end else begin
      cal_state_r <= cal_state_nxt;
      cal_step_r  <= cal_step_nxt;
      cal_code_r  <= cal_code_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  ssrl_cal_s cal_r;
  ssrl_cal_s cal_nxt;
  logic      int_mode_r;
  logic      int_mode_nxt;
  logic      vtune_r;
  logic      vtune_nxt;
  logic      stage_en_r;
  logic      stage_en_nxt;
  logic      mon_r;
  logic      mon_nxt;

  always_comb begin
    cal_nxt.busy        = (cal_state_nxt == SSRL_CAL_RUN);
    cal_nxt.vco_select  = cal_code_nxt[9:8];
    cal_nxt.band_select = cal_code_nxt[7:0];
    // tuning pin is parked on the internal reference while searching
    vtune_nxt    = (cal_state_nxt == SSRL_CAL_RUN);
    int_mode_nxt = (active_nxt.primary_fraction_numerator == 24'h000000) &&
                   (active_nxt.auxiliary_fraction_numerator == 14'h0);
    stage_en_nxt = !active_nxt.mute_until_locked || dlock_s;
    unique case (active_nxt.monitor_select)
      `SSRL_MON_HIGH:   mon_nxt = 1'b1;
      `SSRL_MON_REFDIV: mon_nxt = refclk_s;
      `SSRL_MON_FBDIV:  mon_nxt = fbclk_s;
      `SSRL_MON_ALOCK:  mon_nxt = alock_s;
      `SSRL_MON_DLOCK:  mon_nxt = dlock_s;
      default:          mon_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cal_r      <= '0;
      int_mode_r <= 1'b1;
      vtune_r    <= 1'b0;
      stage_en_r <= 1'b1;
      mon_r      <= 1'b0;
    end else begin
      cal_r      <= cal_nxt;
      int_mode_r <= int_mode_nxt;
      vtune_r    <= vtune_nxt;
      stage_en_r <= stage_en_nxt;
      mon_r      <= mon_nxt;
    end
  end

  assign active_out              = active_r;
  assign cal_out                 = cal_r;
  assign integer_mode_out        = int_mode_r;
  assign vtune_internal_ref_out  = vtune_r;
  assign output_stage_enable_out = stage_en_r;
  assign monitor_output_pin_out  = mon_r;
  assign bad_index_out           = bad_index_r;

endmodule

// ---- verification/ssrl_host_model.sv ----
// Purpose: host side of the three-wire programming link
// Assumes: serial clock period 48 ns, idle low between frames
// Notes:   send is called by the testbench
`timescale 1ns/1ps
module ssrl_host_model
  import ssrl_pkg::*;
(
  output logic serial_clk_out,
  output logic serial_data_out,
  output logic latch_load_strobe_out
);
  initial begin
    serial_clk_out        = 1'b0;
    serial_data_out       = 1'b0;
    latch_load_strobe_out = 1'b0;
  end

  task automatic send(input ssrl_word_t w);
    for (int i = 31; i >= 0; i--) begin
      serial_data_out = w[i];
      #24 serial_clk_out = 1'b1;
      #24 serial_clk_out = 1'b0;
    end
    // no pull on data: show the inverse once its hold has passed
    serial_data_out = ~w[0];
    #24 latch_load_strobe_out = 1'b1;
    #24 latch_load_strobe_out = 1'b0;
  endtask
endmodule

// ---- verification/ssrl_loader_assertions.sv ----
// Purpose: timing relations between loader outputs and their causes
// Assumes: a load lands a few cycles after the strobe pin rises
// Notes:   bound in the testbench file
`timescale 1ns/1ps
module ssrl_loader_assertions
  import ssrl_pkg::*;
(
  input wire logic         clk_in,
  input wire logic         rst_in,
  input wire logic         latch_load_strobe_in,
  input wire logic         digital_lock_in,
  input wire ssrl_active_s active_out,
  input wire ssrl_cal_s    cal_out,
  input wire logic         integer_mode_out,
  input wire logic         vtune_internal_ref_out,
  input wire logic         output_stage_enable_out,
  input wire logic         monitor_output_pin_out,
  input wire logic         bad_index_out
);
  logic [3:0] since_r;
  logic [3:0] since_nxt;
  logic       stb_r;
  logic       stb_nxt;

  // cycles since the strobe pin rose, saturating
  always_comb begin
    stb_nxt   = latch_load_strobe_in;
    since_nxt = since_r;
    if (latch_load_strobe_in && !stb_r) since_nxt = 4'h0;
    else if (since_r != 4'hF) since_nxt = since_r + 4'h1;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stb_r   <= 1'b1;
      since_r <= 4'hF;
    end else begin
      stb_r   <= stb_nxt;
      since_r <= since_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  int_mode_a: assert property (integer_mode_out ==
    (active_out.primary_fraction_numerator == 24'h0 &&
     active_out.auxiliary_fraction_numerator == 14'h0))
    else $error("integer mode flag wrong");
  mute_hold_a: assert property (
    (active_out.mute_until_locked && !digital_lock_in)[*4]
    |-> !output_stage_enable_out) else $error("stage on without lock");
  unmute_a: assert property (!active_out.mute_until_locked
    |-> output_stage_enable_out) else $error("stage off without mute");
  vtune_cal_a: assert property (
    vtune_internal_ref_out == cal_out.busy)
    else $error("tuning source not tied to calibration");
  cal_start_a: assert property ($rose(cal_out.busy) |->
    cal_out.vco_select == 2'h2 && cal_out.band_select == 8'h00)
    else $error("calibration start code wrong");
  cal_hold_a: assert property (!cal_out.busy ##1 !cal_out.busy
    |-> $stable(cal_out)) else $error("code moved while idle");
  cal_bound_a: assert property ($rose(cal_out.busy) |->
    cal_out.busy[*8] ##[1:1000] !cal_out.busy)
    else $error("calibration length wrong");
  mon_fixed_a: assert property (
    active_out.monitor_select inside {3'h0, 3'h1, 3'h2, 3'h7} |->
    monitor_output_pin_out == (active_out.monitor_select == 3'h1))
    else $error("monitor fixed level wrong");
  load_only_a: assert property (
    ($changed(active_out) || $changed(bad_index_out))
    |-> since_r < 4'h8) else $error("settings changed without load");

  cal_run_c: cover property ($rose(cal_out.busy));
  bad_idx_c: cover property ($rose(bad_index_out));
  muted_c: cover property ($fell(output_stage_enable_out));
endmodule

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the serial loader
// Assumes: host model drives the link, bench drives the rest
// Notes:   both lock levels are driven by the bench
`timescale 1ns/1ps
module testbench;
  import ssrl_pkg::*;
  logic         clk_in    = 1'b0;
  logic         rst_in    = 1'b1;
  logic         dlock     = 1'b0;
  logic         ref_clk   = 1'b0;
  logic         fb_clk    = 1'b0;
  logic         tune_high = 1'b0;
  logic         alock     = 1'b0;
  logic         sclk;
  logic         sdat;
  logic         strobe_pin;
  ssrl_active_s act;
  ssrl_cal_s    cal;
  logic         int_mode;
  logic         vtune;
  logic         stage_en;
  logic         mon;
  logic         bad;
  int           err_total   = 0;
  int           check_count = 0;
  ssrl_word_t   w4;

  always #2.5 clk_in = ~clk_in;
  always #20 ref_clk = ~ref_clk;
  always #13 fb_clk = ~fb_clk;

  ssrl_host_model host (
    .serial_clk_out       (sclk),
    .serial_data_out      (sdat),
    .latch_load_strobe_out(strobe_pin)
  );

  ssrl_loader uut (
    .clk_in                 (clk_in),
    .rst_in                 (rst_in),
    .serial_clk_in          (sclk),
    .serial_data_in         (sdat),
    .latch_load_strobe_in   (strobe_pin),
    .digital_lock_in        (dlock),
    .analog_lock_in         (alock),
    .ref_div_clk_in         (ref_clk),
    .feedback_div_clk_in    (fb_clk),
    .tune_high_in           (tune_high),
    .active_out             (act),
    .cal_out                (cal),
    .integer_mode_out       (int_mode),
    .vtune_internal_ref_out (vtune),
    .output_stage_enable_out(stage_en),
    .monitor_output_pin_out (mon),
    .bad_index_out          (bad)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // load lands within four cycles of the strobe; ten leaves margin
  task automatic put(input ssrl_word_t w);
    host.send(w);
    repeat (10) @(negedge clk_in);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic s_reset;
    chk("int_mode", 32'h1, int_mode);
    chk("stage_en", 32'h1, stage_en);
    chk("active", 32'h1, act === '0);
  endtask

  task automatic s_buffer;
    put({4'h0, 24'h123456, 4'h1});
    put({14'h0005, 14'h0009, 4'h2});
    put({4'h0, 24'hABCDEF, 4'h3});
    chk("pfrac_held", 32'h0, act.primary_fraction_numerator);
    chk("amod_held", 32'h0, act.auxiliary_modulus);
    chk("phase_held", 32'h0, act.phase_value);
    put(32'h0000_0640);
    chk("pfrac", 32'h123456, act.primary_fraction_numerator);
    chk("afrac", 32'h5, act.auxiliary_fraction_numerator);
    chk("amod", 32'h9, act.auxiliary_modulus);
    chk("phase", 32'hABCDEF, act.phase_value);
    chk("int", 32'h64, act.int_value);
    chk("int_mode", 32'h0, int_mode);
    put(32'h0000_0001);
    put({14'h0, 14'h0009, 4'h2});
    put(32'h0000_0640);
    chk("int_mode", 32'h1, int_mode);
  endtask

  task automatic s_bad;
    put(32'h0000_065D);
    chk("bad", 32'h1, bad);
    chk("int_kept", 32'h64, act.int_value);
    put(32'h0000_000C);
    chk("bad", 32'h0, bad);
  endtask

  task automatic s_reg4;
    logic seen_hi;
    logic seen_lo;
    w4 = {2'h0, 3'h0, 2'h3, 10'h005, 1'b0, 4'h7, 3'h5, 3'h0, 4'h4};
    dlock = 1'b1;
    alock = 1'b1;
    for (int k = 0; k < 8; k++) begin
      put(w4 | (k << 27));
      if (k == 3 || k == 4) begin
        // divider outputs run free: both levels must show within 16 cycles
        seen_hi = 1'b0;
        seen_lo = 1'b0;
        repeat (16) begin
          @(negedge clk_in);
          seen_hi = seen_hi | (mon === 1'b1);
          seen_lo = seen_lo | (mon === 1'b0);
        end
        chk("mon_toggle", 32'h1, seen_hi & seen_lo);
      end else begin
        chk("mon", (k == 1) || (k == 5) || (k == 6), mon);
      end
    end
    chk("refdiff", 32'h1, act.ref_differential);
    chk("pd_pos", 32'h1, act.pd_positive);
    chk("dbl_held", 32'h0, act.ref_doubler);
    put(32'h0000_0640);
    chk("doubler", 32'h1, act.ref_doubler);
    chk("halver", 32'h1, act.reference_halver);
    chk("rcount", 32'h5, act.ref_count);
    chk("cp", 32'h7, act.cp_current);
  endtask

  task automatic s_reg6;
    dlock = 1'b0;
    put({8'h0, 3'h5, 9'h0, 1'b1, 5'h0, 2'h3, 4'h6});
    chk("div_now", 32'h5, act.out_div);
    chk("power", 32'h3, act.out_power);
    chk("stage_off", 32'h0, stage_en);
    dlock = 1'b1;
    repeat (10) @(negedge clk_in);
    chk("stage_on", 32'h1, stage_en);
    put(w4 | 32'h3800_4000);
    put({8'h0, 3'h2, 9'h0, 1'b1, 5'h0, 2'h3, 4'h6});
    chk("div_held", 32'h5, act.out_div);
    put(32'h0000_0640);
    chk("div", 32'h2, act.out_div);
  endtask

  task automatic s_cal;
    for (int t = 0; t < 2; t++) begin
      tune_high = t[0];
      put(32'h0020_0640);
      chk("busy", 32'h1, cal.busy);
      for (int n = 0; cal.busy !== 1'b0; n++) begin
        if (n == 2000) begin
          err_total++;
          wrap_up();
        end
        @(negedge clk_in);
      end
      chk("vco", t ? 32'h0 : 32'h3, cal.vco_select);
      chk("band", t ? 32'h0 : 32'hFF, cal.band_select);
      chk("vtune", 32'h0, vtune);
    end
  endtask

  initial begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    s_reset();
    s_buffer();
    s_bad();
    s_reg4();
    s_reg6();
    s_cal();
    wrap_up();
  end
endmodule

bind ssrl_loader ssrl_loader_assertions chk_i (
  .clk_in                 (clk_in),
  .rst_in                 (rst_in),
  .latch_load_strobe_in   (latch_load_strobe_in),
  .digital_lock_in        (digital_lock_in),
  .active_out             (active_out),
  .cal_out                (cal_out),
  .integer_mode_out       (integer_mode_out),
  .vtune_internal_ref_out (vtune_internal_ref_out),
  .output_stage_enable_out(output_stage_enable_out),
  .monitor_output_pin_out (monitor_output_pin_out),
  .bad_index_out          (bad_index_out)
);
